/* mmutc_pkg.sv */
// package for the memory-management translation control block
// assumes a single core clock domain and an avalon-mm register master
package mmutc_pkg;
  // register byte offsets on the avalon bus
  localparam logic [7:0] MMUTC_OFS_XCTX_LO = 8'h00;
  localparam logic [7:0] MMUTC_OFS_XCTX_HI = 8'h04;
  localparam logic [7:0] MMUTC_OFS_USER_INSTR_BASE = 8'h08;
  localparam logic [7:0] MMUTC_OFS_USER_INSTR_BOUND = 8'h0c;
  localparam logic [7:0] MMUTC_OFS_USER_DATA_BASE = 8'h10;
  localparam logic [7:0] MMUTC_OFS_USER_DATA_BOUND = 8'h14;
  localparam logic [7:0] MMUTC_OFS_CPMAP = 8'h18;
  localparam logic [7:0] MMUTC_OFS_EHI = 8'h1c;
  localparam logic [7:0] MMUTC_OFS_ELO = 8'h20;
  localparam logic [7:0] MMUTC_OFS_INDEX = 8'h24;
  localparam logic [7:0] MMUTC_OFS_RANDOM = 8'h28;
  localparam logic [7:0] MMUTC_OFS_WIRED = 8'h2c;
  localparam logic [7:0] MMUTC_OFS_STATUS = 8'h30;
  localparam logic [7:0] MMUTC_OFS_CMD = 8'h34;
  localparam logic [7:0] MMUTC_OFS_ASID = 8'h38;
  // reset values and field masks
  localparam logic [31:0] MMUTC_CPMAP_RESET = 32'h22233333;
  localparam logic [31:0] MMUTC_CPMAP_MASK = 32'h77777777;
  localparam logic [31:0] MMUTC_BASE_MASK = 32'hfffff000;
  localparam logic [31:0] MMUTC_UNMAPPED_READ = 32'h00000000;
  // extended refill context layout
  localparam int MMUTC_XCTX_VPN_LSB = 4;
  localparam int MMUTC_XCTX_R_LSB = 31;
  localparam int MMUTC_XCTX_BASE_LSB = 33;
  localparam int MMUTC_VA_VPN2_LSB = 13;
  localparam int MMUTC_VA_VPN2_W = 27;
  localparam int MMUTC_PAGE_LSB = 12;
  // refill vectors
  localparam logic [31:0] MMUTC_VEC_REFILL32 = 32'h80000000;
  localparam logic [31:0] MMUTC_VEC_REFILL64 = 32'h80000080;
  localparam logic [31:0] MMUTC_VEC_GENERAL = 32'h80000180;
  // maintenance command codes, written to the command register
  localparam logic [2:0] MMUTC_CMD_READ = 3'h1;
  localparam logic [2:0] MMUTC_CMD_WRITE_IDX = 3'h2;
  localparam logic [2:0] MMUTC_CMD_WRITE_RND = 3'h3;
  localparam logic [2:0] MMUTC_CMD_PROBE = 3'h4;
  // status bits
  localparam int MMUTC_ST_SHUTDOWN = 0;
  localparam int MMUTC_ST_KU_OLD = 1;
  localparam int MMUTC_ST_IE_OLD = 2;

  // one translation entry
  typedef struct packed {
    logic [18:0] vpn2;
    logic [7:0] asid;
    logic global_match;
    logic [31:0] low;
  } mmutc_entry_type;

  // lookup request from the pipeline
  typedef struct packed {
    logic valid;
    logic fetch;
    logic user;
    logic addr64;
    logic [63:0] vaddr;
  } mmutc_req_type;

  // translation answer to the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] paddr;
    logic [3:0] cache_alg;
    logic addr_error;
    logic refill;
    logic [31:0] vector;
  } mmutc_resp_type;
endpackage : mmutc_pkg

/* mmutc_core.sv */
// translation control: context, base/bound, cache policy map and tlb ops
// assumes one core clock, an avalon-mm master and a pipeline driving req_in
//
// Summary of operation
// - on miss, load faulting page pair number with virtual bits 39:13
// - on miss, record virtual bits 63:62 as address region
// - page table base field holds whatever software last wrote
// - user physical address is base value plus virtual bits 31:12
// - user fetch beyond instruction bound raises address error
// - user data page bits compared against data bound value
// - reserved base/bound bits read zero; software writes zeros
// - cache policy map read/write, one selector per 512MB region
// - cache policy map resets to 0x22233333
// - top bit of each four-bit selector reads zero, ignores writes
// - selector codes: 0 wt, 1 wt-alloc, 2 uncached, 3 write-back
// - selector n covers addresses whose top three bits equal n
// - indexed read fills staging registers; indexed write stores them
// - random write stores staging registers at replacement counter entry
// - probe stores matching index or negative value, no data fetch
// - duplicate match in small variant sets sticky shutdown flag until reset
// - access to mapped page without entry takes refill exception
// - user refills vector to dedicated address, separate for 64-bit space
// - refill loads entry-high staging with current tag and faulting page
// - old mode and interrupt bits form third level of status stack
// - non-global entry matches only when its tag, under the tag mask, equals current tag
// - top bit of entry select set when probe found no match
// - replacement counter reset to upper bound, also on pinned count write
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module mmutc_core
  import mmutc_pkg::*;
#(
  parameter int ENTRIES = 48,
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire mmutc_req_type req_in,
  input wire logic [1:0] mode_stack_in,
  output mmutc_resp_type resp_out,
  output logic shutdown_out
);
  localparam int IW = $clog2(ENTRIES);
  localparam logic [IW-1:0] TOP_IDX = IW'(ENTRIES - 1);

  mmutc_entry_type tlb_q [ENTRIES];
  logic [63:0] xctx_q;
  logic [31:0] user_instr_base_q, user_instr_bound_q, user_data_base_q, user_data_bound_q, cpmap_q;
  logic [31:0] ehi_q, elo_q;
  logic probe_fail_q;
  logic [IW-1:0] index_q, random_q, wired_q;
  logic shutdown_q;
  logic [1:0] old_stack_q;
  logic [7:0] asid_q;
  logic ack_q;
  mmutc_resp_type resp_q;

  // byte-lane merge, shared by the context, base/bound, policy map and staging register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // entry match against a page pair and tag
  function automatic logic hit(input mmutc_entry_type e, input logic [18:0] vpn2,
                               input logic [7:0] tag, input logic [7:0] tmask);
    return (e.vpn2 == vpn2) && (e.global_match || ((e.asid & tmask) == (tag & tmask)));
  endfunction : hit

  // tag width shrinks to 64 tags in the small variant
  logic [7:0] tag_mask;
  assign tag_mask = SMALL_VARIANT ? 8'h3f : 8'hff;

  // one-cycle bus answer: waitrequest drops one edge after the request
  logic bus_req, wr_acc;
  assign bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~ack_q;
  assign wr_acc = avs_write_in & ack_q & clk_en_in;
  assign shutdown_out = shutdown_q;
  assign resp_out = resp_q;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
    end else if (clk_en_in) begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // probe search over the whole array on the staging entry-high
  logic [IW-1:0] probe_idx;
  logic [7:0] probe_cnt;
  always_comb begin
    probe_idx = '0;
    probe_cnt = 8'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hit(tlb_q[i], ehi_q[31:13], ehi_q[7:0], tag_mask)) begin
        probe_idx = IW'(i);
        probe_cnt = probe_cnt + 8'h01;
      end
    end
  end

  // translation search for the pipeline address
  logic [IW-1:0] tr_idx;
  logic [7:0] tr_cnt;
  always_comb begin
    tr_idx = '0;
    tr_cnt = 8'h00;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hit(tlb_q[i], req_in.vaddr[31:13], asid_q, tag_mask)) begin
        tr_idx = IW'(i);
        tr_cnt = tr_cnt + 8'h01;
      end
    end
  end

  logic cmd_wr;
  logic [2:0] cmd;
  assign cmd_wr = wr_acc && (avs_address_in == MMUTC_OFS_CMD);
  assign cmd = avs_writedata_in[2:0];

  // translation path: user base/bound, mapped lookup, cache policy
  logic [2:0] region;
  logic mapped, miss, dup_hit, bound_err;
  logic [19:0] page;
  logic [31:0] sel_base, sel_bound;
  assign region = req_in.vaddr[31:29];
  assign page = req_in.vaddr[31:12];
  assign sel_base = req_in.fetch ? user_instr_base_q : user_data_base_q;
  assign sel_bound = req_in.fetch ? user_instr_bound_q : user_data_bound_q;
  // kernel view: user regions 0-3 and regions 6,7 use the array; 4 and 5 are direct
  assign mapped = ~req_in.user && (~region[2] || (region[2:1] == 2'b11));
  assign miss = mapped && (tr_cnt == 8'h00);
  assign dup_hit = SMALL_VARIANT && (tr_cnt > 8'h01);
  // fetch and data both compare page bits against their own bound
  assign bound_err = req_in.user && (page > sel_bound[31:12]);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      resp_q <= '0;
    end else if (clk_en_in) begin
      resp_q.valid <= req_in.valid & ~shutdown_q;
      resp_q.cache_alg <= 4'(cpmap_q[region*4 +: 4]);
      resp_q.addr_error <= req_in.valid & bound_err;
      resp_q.refill <= req_in.valid & miss & ~bound_err;
      if (req_in.user) begin
        resp_q.paddr <= {sel_base[31:12] + page, req_in.vaddr[11:0]};
      end else if (mapped) begin
        resp_q.paddr <= {tlb_q[tr_idx].low[31:12], req_in.vaddr[11:0]};
      end else begin
        resp_q.paddr <= {3'h0, req_in.vaddr[28:0]};
      end
      // user-segment refills take the dedicated vector
      if (miss && ~req_in.vaddr[31]) begin
        resp_q.vector <= req_in.addr64 ? MMUTC_VEC_REFILL64 : MMUTC_VEC_REFILL32;
      end else begin
        resp_q.vector <= MMUTC_VEC_GENERAL;
      end
    end
  end

  // extended refill context: hardware fills bad page and region
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      xctx_q <= '0;
    end else if (clk_en_in) begin
      if (wr_acc && avs_address_in == MMUTC_OFS_XCTX_HI) begin
        xctx_q[63:32] <= merge(xctx_q[63:32], avs_writedata_in, avs_byteenable_in);
      end
      if (req_in.valid && miss) begin
        xctx_q[MMUTC_XCTX_VPN_LSB +: MMUTC_VA_VPN2_W] <= req_in.vaddr[39:13];
        xctx_q[MMUTC_XCTX_R_LSB +: 2] <= req_in.vaddr[63:62];
      end
      xctx_q[3:0] <= 4'h0;
    end
  end

  // base and bound registers keep only the page bits
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      user_instr_base_q <= '0;
      user_instr_bound_q <= '0;
      user_data_base_q <= '0;
      user_data_bound_q <= '0;
    end else if (wr_acc) begin
      unique case (avs_address_in)
        MMUTC_OFS_USER_INSTR_BASE: user_instr_base_q <= merge(user_instr_base_q, avs_writedata_in, avs_byteenable_in)
                                    & MMUTC_BASE_MASK;
        MMUTC_OFS_USER_INSTR_BOUND: user_instr_bound_q <= merge(user_instr_bound_q, avs_writedata_in, avs_byteenable_in)
                                      & MMUTC_BASE_MASK;
        MMUTC_OFS_USER_DATA_BASE: user_data_base_q <= merge(user_data_base_q, avs_writedata_in, avs_byteenable_in)
                                    & MMUTC_BASE_MASK;
        MMUTC_OFS_USER_DATA_BOUND: user_data_bound_q <= merge(user_data_bound_q, avs_writedata_in, avs_byteenable_in)
                                      & MMUTC_BASE_MASK;
        default: ;
      endcase
    end
  end

  // cache policy map; top bit of each nibble is not stored
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cpmap_q <= MMUTC_CPMAP_RESET;
    end else if (wr_acc && avs_address_in == MMUTC_OFS_CPMAP) begin
      cpmap_q <= merge(cpmap_q, avs_writedata_in, avs_byteenable_in)
                 & MMUTC_CPMAP_MASK;
    end
  end

  // staging registers: software writes, indexed read, refill load
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ehi_q <= '0;
      elo_q <= '0;
    end else if (clk_en_in) begin
      if (cmd_wr && cmd == MMUTC_CMD_READ) begin
        ehi_q <= {tlb_q[index_q].vpn2, 5'h0, tlb_q[index_q].asid};
        elo_q <= {tlb_q[index_q].low[31:1], tlb_q[index_q].global_match};
      end else if (req_in.valid && miss) begin
        ehi_q <= {req_in.vaddr[31:13], 5'h0, asid_q};
      end else if (wr_acc && avs_address_in == MMUTC_OFS_EHI) begin
        ehi_q <= merge(ehi_q, avs_writedata_in, avs_byteenable_in) & 32'hffffe0ff;
      end else if (wr_acc && avs_address_in == MMUTC_OFS_ELO) begin
        elo_q <= merge(elo_q, avs_writedata_in, avs_byteenable_in);
      end
    end
  end

  // entry array writes, indexed or at the replacement counter
  logic [IW-1:0] wr_idx;
  logic tlb_we;
  assign tlb_we = cmd_wr && (cmd == MMUTC_CMD_WRITE_IDX || cmd == MMUTC_CMD_WRITE_RND);
  assign wr_idx = (cmd == MMUTC_CMD_WRITE_RND) ? random_q : index_q;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tlb_q[i] <= '0;
      end
    end else if (clk_en_in && tlb_we) begin
      tlb_q[wr_idx] <= '{vpn2: ehi_q[31:13], asid: ehi_q[7:0],
                         global_match: elo_q[0], low: elo_q};
    end
  end

  // entry select and probe result; probe never touches entry data
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      index_q <= '0;
      probe_fail_q <= 1'b0;
    end else if (clk_en_in) begin
      if (cmd_wr && cmd == MMUTC_CMD_PROBE) begin
        probe_fail_q <= (probe_cnt == 8'h00);
        index_q <= probe_idx;
      end else if (wr_acc && avs_address_in == MMUTC_OFS_INDEX) begin
        index_q <= avs_writedata_in[IW-1:0];
      end
    end
  end

  // replacement counter counts down from top to the pinned boundary
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      random_q <= TOP_IDX;
      wired_q <= '0;
    end else if (clk_en_in) begin
      if (wr_acc && avs_address_in == MMUTC_OFS_WIRED) begin
        wired_q <= avs_writedata_in[IW-1:0];
        random_q <= TOP_IDX;
      end else if (random_q <= wired_q) begin
        random_q <= TOP_IDX;
      end else begin
        random_q <= random_q - 1'b1;
      end
    end
  end

  // shutdown is sticky; a pipeline that obeys the probe spacing needs no stall
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shutdown_q <= 1'b0;
    end else if (clk_en_in && SMALL_VARIANT) begin
      if ((req_in.valid && mapped && dup_hit) ||
          (cmd_wr && cmd == MMUTC_CMD_PROBE && probe_cnt > 8'h01)) begin
        shutdown_q <= 1'b1;
      end
    end
  end

  // old mode/interrupt pair, pushed on each refill of the small variant
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      old_stack_q <= '0;
      asid_q <= '0;
    end else if (clk_en_in) begin
      if (SMALL_VARIANT && req_in.valid && miss) begin
        old_stack_q <= mode_stack_in;
      end else if (wr_acc && avs_address_in == MMUTC_OFS_STATUS) begin
        old_stack_q <= avs_writedata_in[2:1];
      end
      if (wr_acc && avs_address_in == MMUTC_OFS_ASID) begin
        asid_q <= avs_writedata_in[7:0] & tag_mask;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      avs_readdata_out <= '0;
    end else if (clk_en_in && avs_read_in && ~ack_q) begin
      unique case (avs_address_in)
        MMUTC_OFS_XCTX_LO: avs_readdata_out <= xctx_q[31:0];
        MMUTC_OFS_XCTX_HI: avs_readdata_out <= xctx_q[63:32];
        MMUTC_OFS_USER_INSTR_BASE: avs_readdata_out <= user_instr_base_q;
        MMUTC_OFS_USER_INSTR_BOUND: avs_readdata_out <= user_instr_bound_q;
        MMUTC_OFS_USER_DATA_BASE: avs_readdata_out <= user_data_base_q;
        MMUTC_OFS_USER_DATA_BOUND: avs_readdata_out <= user_data_bound_q;
        MMUTC_OFS_CPMAP: avs_readdata_out <= cpmap_q;
        MMUTC_OFS_EHI: avs_readdata_out <= ehi_q;
        MMUTC_OFS_ELO: avs_readdata_out <= elo_q;
        MMUTC_OFS_INDEX: avs_readdata_out <= {probe_fail_q, 31'(index_q)};
        MMUTC_OFS_RANDOM: avs_readdata_out <= 32'(random_q);
        MMUTC_OFS_WIRED: avs_readdata_out <= 32'(wired_q);
        MMUTC_OFS_STATUS: avs_readdata_out <= {29'h0, old_stack_q, shutdown_q};
        MMUTC_OFS_ASID: avs_readdata_out <= {24'h0, asid_q};
        default: avs_readdata_out <= MMUTC_UNMAPPED_READ;
      endcase
    end
  end
endmodule : mmutc_core

/* mmutc_core_asserts.sv */
// port-level checks for the translation control block
// assumes full byte enables and clk_en_in high while the bench runs
`timescale 1ns/100ps
module mmutc_core_asserts
  import mmutc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire mmutc_req_type req_in,
  input wire mmutc_resp_type resp_out,
  input wire logic shutdown_out
);
  logic [31:0] sh_q [0:15];
  logic [31:0] pa_d;
  logic ack;
  assign ack = clk_en_in && !avs_waitrequest_out;
  // shadow of software writes, so checks know what each register holds
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 16; i++)
        sh_q[i] <= (i == 6) ? MMUTC_CPMAP_RESET : 32'h00000000;
    end else if (avs_write_in && ack) begin
      sh_q[avs_address_in[5:2]] <= avs_writedata_in;
    end
  end
  // expected user physical address for the lookup now presented
  assign pa_d = ((req_in.fetch ? sh_q[2] : sh_q[4]) & MMUTC_BASE_MASK) + req_in.vaddr[31:0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  cpmap_read_a: assert property (
    avs_read_in && ack && avs_address_in == MMUTC_OFS_CPMAP
    |-> avs_readdata_out == (sh_q[6] & MMUTC_CPMAP_MASK))
    else $error("cache policy map read differs from written value");
  rsvd_read_a: assert property (
    avs_read_in && ack && avs_address_in >= MMUTC_OFS_USER_INSTR_BASE && avs_address_in <= MMUTC_OFS_USER_DATA_BOUND
    |-> (avs_readdata_out & ~MMUTC_BASE_MASK) == 32'h00000000)
    else $error("reserved base or bound bits read nonzero");
  ctx_base_a: assert property (
    avs_read_in && ack && avs_address_in == MMUTC_OFS_XCTX_HI
    |-> avs_readdata_out[31:1] == sh_q[1][31:1])
    else $error("page table base lost its written value");
  region_alg_a: assert property (
    req_in.valid && req_in.vaddr[31:30] != 2'h3
    |=> resp_out.valid && resp_out.cache_alg == (4'(sh_q[6] >> {$past(req_in.vaddr[31:29]), 2'h0}) & 4'h7))
    else $error("cache selector not taken from the address region");
  user_instr_bound_err_a: assert property (
    req_in.valid && req_in.fetch && req_in.user && req_in.vaddr[31:12] > sh_q[3][31:12]
    |=> resp_out.addr_error)
    else $error("fetch beyond instruction bound not refused");
  user_data_bound_err_a: assert property (
    req_in.valid && !req_in.fetch && req_in.user && req_in.vaddr[31:12] > sh_q[5][31:12]
    |=> resp_out.addr_error)
    else $error("data access beyond data bound not refused");
  user_paddr_a: assert property (
    req_in.valid && req_in.user && !req_in.addr64
    && req_in.vaddr[31:12] <= (req_in.fetch ? sh_q[3][31:12] : sh_q[5][31:12])
    |=> !resp_out.addr_error && resp_out.paddr == $past(pa_d))
    else $error("user physical address is not base plus virtual address");
  shutdown_hold_a: assert property (
    shutdown_out |=> shutdown_out)
    else $error("shutdown flag dropped without reset");
endmodule : mmutc_core_asserts

bind mmutc_core mmutc_core_asserts chk_i (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .req_in(req_in), .resp_out(resp_out),
  .shutdown_out(shutdown_out)
);

/* mmutc_pipe_model.sv */
// pipeline model: issues one-cycle lookups and collects the answer
// assumes the bench calls lookup from one process, just after an edge
`timescale 1ns/100ps
module mmutc_pipe_model
  import mmutc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic probe_seen_in,
  input wire mmutc_resp_type resp_in,
  output mmutc_req_type req_out
);
  logic gap_q;
  initial req_out = '0;
  // remember a probe so the slot right after it stays free of loads
  always_ff @(posedge ref_clk_in) begin
    gap_q <= probe_seen_in;
  end
  task automatic lookup(input mmutc_req_type rq, output mmutc_resp_type ans);
    @(posedge ref_clk_in);
    if (gap_q)
      @(posedge ref_clk_in);
    req_out <= rq;
    @(posedge ref_clk_in);
    req_out.valid <= 1'b0;
    @(posedge ref_clk_in);
    ans = resp_in;
  endtask : lookup
endmodule : mmutc_pipe_model

/* mmutc_core_test.sv */
// self-checking bench for the translation control block
// assumes the pipeline model beside the dut and the bound checker
`timescale 1ns/100ps
module mmutc_core_test;
  import mmutc_pkg::*;
  localparam int N_ENT = 16;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [1:0] mode_stack_in = 2'h0;
  mmutc_req_type req_in;
  mmutc_resp_type resp_out, a;
  logic shutdown_out, probe_seen, f, err;
  logic [31:0] q, v, ms, ehi, elo, bd;
  logic [31:0] bb [0:3];
  logic [63:0] va;
  int n_mismatch = 0;
  int tests_run = 0;
  mmutc_core #(.ENTRIES(N_ENT), .SMALL_VARIANT(1'b1)) dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .req_in(req_in), .mode_stack_in(mode_stack_in), .resp_out(resp_out),
    .shutdown_out(shutdown_out)
  );
  // probe landing edge, so the model keeps the next slot clear
  assign probe_seen = avs_write_in && !avs_waitrequest_out && avs_address_in == MMUTC_OFS_CMD
    && avs_writedata_in[2:0] == MMUTC_CMD_PROBE;
  mmutc_pipe_model pipe (
    .ref_clk_in(ref_clk_in), .probe_seen_in(probe_seen), .resp_in(resp_out), .req_out(req_in)
  );
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= adr;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      n++;
      if (n > 40) begin
        n_mismatch++;
        report_and_stop();
      end
      @(posedge ref_clk_in);
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : bus
  task automatic look(input logic fe, input logic u, input logic w, input logic [63:0] x);
    pipe.lookup('{valid: 1'b1, fetch: fe, user: u, addr64: w, vaddr: x}, a);
  endtask : look
  function automatic logic [31:0] alg_of(input logic [31:0] m, input logic [2:0] n);
    return (m >> {n, 2'h0}) & 32'h00000007;
  endfunction : alg_of
  function automatic logic [31:0] ctx_lo(input logic [63:0] x);
    return {x[62], x[39:13], 4'h0};
  endfunction : ctx_lo
  // main sequence: registers, lookups, refill, maintenance, shutdown
  initial begin
    void'($urandom(53669));
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    bus(0, MMUTC_OFS_CPMAP, 0);
    chk(q, MMUTC_CPMAP_RESET);
    bus(0, 8'h3c, 0);
    chk(q, MMUTC_UNMAPPED_READ);
    for (int k = 0; k < 3; k++) begin
      v = $urandom();
      bus(1, MMUTC_OFS_CPMAP, v);
      bus(0, MMUTC_OFS_CPMAP, 0);
      chk(q, v & MMUTC_CPMAP_MASK);
    end
    for (int k = 0; k < 6; k++) begin
      look(1'b0, 1'b1, 1'b0, {32'h0, k[2:0], 29'h00001234});
      chk({28'h0, a.cache_alg}, alg_of(v, k[2:0]));
    end
    for (int k = 0; k < 4; k++) begin
      v = $urandom();
      if (k[0])
        v[31:30] = 2'h1;
      bb[k] = v & MMUTC_BASE_MASK;
      bus(1, MMUTC_OFS_USER_INSTR_BASE + 8'(4 * k), v);
      bus(0, MMUTC_OFS_USER_INSTR_BASE + 8'(4 * k), 0);
      chk(q, bb[k]);
    end
    // random user lookups land on both sides of each bound
    for (int k = 0; k < 12; k++) begin
      f = k[0];
      va = {33'h0, 31'($urandom())};
      look(f, 1'b1, 1'b0, va);
      bd = f ? bb[1] : bb[3];
      err = va[31:12] > bd[31:12];
      chk({31'h0, a.addr_error}, {31'h0, err});
      if (!err)
        chk(a.paddr, (f ? bb[0] : bb[2]) + va[31:0]);
    end
    ms = $urandom();
    v = $urandom();
    mode_stack_in <= ms[1:0];
    bus(1, MMUTC_OFS_XCTX_HI, v);
    bus(1, MMUTC_OFS_ASID, {26'h0, ms[7:2]});
    va = {2'h1, 30'($urandom()), 2'h1, 30'($urandom())};
    look(1'b0, 1'b0, 1'b1, va);
    chk({31'h0, a.refill}, 32'h1);
    chk(a.vector, MMUTC_VEC_REFILL64);
    bus(0, MMUTC_OFS_XCTX_LO, 0);
    chk(q, ctx_lo(va));
    bus(0, MMUTC_OFS_XCTX_HI, 0);
    chk(q, {v[31:1], va[63]});
    bus(0, MMUTC_OFS_EHI, 0);
    chk(q, {va[31:13], 7'h0, ms[7:2]});
    bus(0, MMUTC_OFS_STATUS, 0);
    chk({30'h0, q[2:1]}, {30'h0, ms[1:0]});
    look(1'b0, 1'b0, 1'b0, {32'h0, 3'h1, 29'($urandom())});
    chk({31'h0, a.refill}, 32'h1);
    chk(a.vector, MMUTC_VEC_REFILL32);
    // a miss in the mapped kernel segment takes the general vector
    look(1'b0, 1'b0, 1'b0, {32'h0, 3'h6, 29'($urandom())});
    chk({31'h0, a.refill}, 32'h1);
    chk(a.vector, MMUTC_VEC_GENERAL);
    // indexed write, overwrite staging, read back, then probe
    ehi = {$urandom() | 32'hc0000000} & 32'hffffe03f;
    elo = $urandom() & 32'hfffffffe;
    bus(1, MMUTC_OFS_EHI, ehi);
    bus(1, MMUTC_OFS_ELO, elo);
    bus(1, MMUTC_OFS_INDEX, 32'h5);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_WRITE_IDX});
    bus(1, MMUTC_OFS_EHI, 32'h0);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_READ});
    bus(0, MMUTC_OFS_EHI, 0);
    chk(q, ehi);
    bus(0, MMUTC_OFS_ELO, 0);
    chk(q, elo);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_PROBE});
    bus(0, MMUTC_OFS_INDEX, 0);
    chk(q, 32'h5);
    bus(1, MMUTC_OFS_EHI, ehi ^ 32'h1);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_PROBE});
    bus(0, MMUTC_OFS_INDEX, 0);
    chk({31'h0, q[31]}, 32'h1);
    // global entry matches under any tag, also right after a probe
    ehi = (ehi ^ 32'h00100000) & 32'hffffe000;
    bus(1, MMUTC_OFS_EHI, ehi);
    bus(1, MMUTC_OFS_ELO, 32'h1);
    bus(1, MMUTC_OFS_INDEX, 32'h6);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_WRITE_IDX});
    bus(1, MMUTC_OFS_EHI, ehi | 32'h2a);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_PROBE});
    look(1'b0, 1'b0, 1'b0, {32'h0, ehi[31:13], 13'h0});
    chk({31'h0, a.refill}, 32'h0);
    bus(0, MMUTC_OFS_INDEX, 0);
    chk(q, 32'h6);
    // random write lands above the pinned entries
    ehi = ehi ^ 32'h00200000;
    bus(1, MMUTC_OFS_WIRED, 32'ha);
    bus(1, MMUTC_OFS_EHI, ehi);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_WRITE_RND});
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_PROBE});
    bus(0, MMUTC_OFS_INDEX, 0);
    chk({31'h0, q >= 32'ha && q < N_ENT}, 32'h1);
    // duplicate entry, then a probe shuts the unit down until reset
    bus(1, MMUTC_OFS_INDEX, 32'h2);
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_WRITE_IDX});
    bus(1, MMUTC_OFS_CMD, {29'h0, MMUTC_CMD_PROBE});
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, shutdown_out}, 32'h1);
    reset_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    chk({31'h0, shutdown_out}, 32'h0);
    report_and_stop();
  end
endmodule : mmutc_core_test
